/* hdl/lpa_pkg.sv */
package lpa_pkg;

    // =========================================================================
    // Management frame layout
    // =========================================================================
    localparam logic [4:0] LPA_REG_ADDR = 5'h05;
    localparam logic [5:0] LPA_PRE_LEN = 6'h20;
    localparam logic [4:0] LPA_HDR_LAST = 5'h0c;
    localparam logic [4:0] LPA_TA_LAST = 5'h01;
    localparam logic [4:0] LPA_DATA_LAST = 5'h0f;
    localparam logic [4:0] LPA_DATA_BITS = 5'h10;
    localparam logic [1:0] LPA_OP_READ = 2'h2;
    localparam logic [1:0] LPA_OP_WRITE = 2'h1;

    // =========================================================================
    // Register fields
    // =========================================================================
    localparam logic [15:0] LPA_RESET = 16'h0000;
    localparam int LPA_NEXT_PAGE = 15;
    localparam int LPA_ACK = 14;
    localparam int LPA_REMOTE_FAULT = 13;
    localparam int LPA_RSVD_HI = 12;
    localparam int LPA_RSVD_LO = 10;
    localparam int LPA_T4 = 9;
    localparam int LPA_TECH_HI = 8;
    localparam int LPA_TECH_LO = 5;
    localparam int LPA_SEL_HI = 4;
    localparam int LPA_OVR_HI = 3;

    typedef enum logic [2:0] {
        LPA_PRE = 3'b000,
        LPA_HDR = 3'b001,
        LPA_TA_RD = 3'b010,
        LPA_DATA_RD = 3'b011,
        LPA_TA_WR = 3'b100,
        LPA_DATA_WR = 3'b101
    } lpa_state_t;

endpackage

/* hdl/lpa_ability_reg.sv */
module lpa_ability_reg (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] code_word,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic command_override_write,
    output logic [15:0] value
);

    logic [15:0] value_reg;
    logic [15:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (load) begin
            value_next = code_word;
        end else if (wr_en && command_override_write) begin
            value_next[lpa_pkg::LPA_OVR_HI:0] = wr_data[lpa_pkg::LPA_OVR_HI:0];
        end
        // Fixed zeros are forced after every update so no path can set them.
        value_next[lpa_pkg::LPA_RSVD_HI:lpa_pkg::LPA_RSVD_LO] = 3'h0;
        value_next[lpa_pkg::LPA_T4] = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            value_reg <= lpa_pkg::LPA_RESET;
        end else begin
            value_reg <= value_next;
        end
    end

    // Bit 15 next page, 14 acknowledge, 13 remote fault, 8:5 technologies,
    // 4:0 selector code are loaded from the code word; writes with command_override_write high can replace bits 3:0.
    assign value = value_reg;

endmodule // lpa_ability_reg

/* hdl/lpa_mgmt.sv */
module lpa_mgmt (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    input wire logic command_override_write,
    input wire logic code_word_valid,
    input wire logic [15:0] code_word,
    output logic [15:0] partner_ability
);

    // =========================================================================
    // Pin synchronisers
    // =========================================================================
    logic mdc_s1_reg;
    logic mdc_s2_reg;
    logic mdc_s3_reg;
    logic mdio_s1_reg;
    logic mdio_s2_reg;
    logic [4:0] addr_s1_reg;
    logic [4:0] addr_s2_reg;
    logic mdc_rise;

    always_ff @(posedge mclk) begin
        if (rst) begin
            mdc_s1_reg <= 1'b0;
            mdc_s2_reg <= 1'b0;
            mdc_s3_reg <= 1'b0;
            mdio_s1_reg <= 1'b1;
            mdio_s2_reg <= 1'b1;
            addr_s1_reg <= 5'h00;
            addr_s2_reg <= 5'h00;
        end else begin
            mdc_s1_reg <= mdc;
            mdc_s2_reg <= mdc_s1_reg;
            mdc_s3_reg <= mdc_s2_reg;
            mdio_s1_reg <= mdio_in;
            mdio_s2_reg <= mdio_s1_reg;
            addr_s1_reg <= phy_addr;
            addr_s2_reg <= addr_s1_reg;
        end
    end

    // The third flop only delays the clock pin for edge detection.
    // The data pin is read from its second flop at the detected rise, long after it settled.
    assign mdc_rise = mdc_s2_reg && !mdc_s3_reg;

    // =========================================================================
    // Frame engine
    // =========================================================================
    lpa_pkg::lpa_state_t state_reg;
    lpa_pkg::lpa_state_t state_next;
    logic [5:0] pre_cnt_reg;
    logic [5:0] pre_cnt_next;
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic [11:0] hdr_reg;
    logic [11:0] hdr_next;
    logic [15:0] data_reg;
    logic [15:0] data_next;
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic wr_en_reg;
    logic wr_en_next;
    logic [15:0] wr_data_reg;
    logic [15:0] wr_data_next;
    logic [12:0] hdr_full;
    logic [15:0] reg_value;
    logic frame_ours;

    assign hdr_full = {hdr_reg, mdio_s2_reg};
    // A frame is ours only with a start bit of one, our address and this register.
    assign frame_ours = hdr_full[12] && (hdr_full[9:5] == addr_s2_reg)
        && (hdr_full[4:0] == lpa_pkg::LPA_REG_ADDR);

    always_comb begin
        state_next = state_reg;
        pre_cnt_next = pre_cnt_reg;
        bit_cnt_next = bit_cnt_reg;
        hdr_next = hdr_reg;
        data_next = data_reg;
        out_next = out_reg;
        oe_next = oe_reg;
        wr_en_next = 1'b0;
        wr_data_next = wr_data_reg;
        if (mdc_rise) begin
            case (state_reg)
                lpa_pkg::LPA_PRE: begin
                    if (mdio_s2_reg) begin
                        if (pre_cnt_reg != lpa_pkg::LPA_PRE_LEN) begin
                            pre_cnt_next = pre_cnt_reg + 6'h01;
                        end
                    end else if (pre_cnt_reg == lpa_pkg::LPA_PRE_LEN) begin
                        state_next = lpa_pkg::LPA_HDR;
                        bit_cnt_next = 5'h00;
                        pre_cnt_next = 6'h00;
                    end else begin
                        pre_cnt_next = 6'h00;
                    end
                end
                lpa_pkg::LPA_HDR: begin
                    hdr_next = hdr_full[11:0];
                    bit_cnt_next = bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == lpa_pkg::LPA_HDR_LAST) begin
                        bit_cnt_next = 5'h00;
                        state_next = lpa_pkg::LPA_PRE;
                        if (frame_ours && hdr_full[11:10] == lpa_pkg::LPA_OP_READ) begin
                            state_next = lpa_pkg::LPA_TA_RD;
                        end else if (frame_ours && hdr_full[11:10] == lpa_pkg::LPA_OP_WRITE) begin
                            state_next = lpa_pkg::LPA_TA_WR;
                        end
                    end
                end
                lpa_pkg::LPA_TA_RD: begin
                    // Second turnaround bit is driven low, data follows.
                    out_next = 1'b0;
                    oe_next = 1'b1;
                    data_next = reg_value;
                    bit_cnt_next = 5'h00;
                    state_next = lpa_pkg::LPA_DATA_RD;
                end
                lpa_pkg::LPA_DATA_RD: begin
                    if (bit_cnt_reg == lpa_pkg::LPA_DATA_BITS) begin
                        oe_next = 1'b0;
                        out_next = 1'b0;
                        state_next = lpa_pkg::LPA_PRE;
                    end else begin
                        out_next = data_reg[15];
                        data_next = {data_reg[14:0], 1'b0};
                        bit_cnt_next = bit_cnt_reg + 5'h01;
                    end
                end
                lpa_pkg::LPA_TA_WR: begin
                    bit_cnt_next = bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == lpa_pkg::LPA_TA_LAST) begin
                        bit_cnt_next = 5'h00;
                        state_next = lpa_pkg::LPA_DATA_WR;
                    end
                end
                lpa_pkg::LPA_DATA_WR: begin
                    data_next = {data_reg[14:0], mdio_s2_reg};
                    bit_cnt_next = bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == lpa_pkg::LPA_DATA_LAST) begin
                        // The strobe lasts one cycle; a load in that cycle wins in the register.
                        wr_en_next = 1'b1;
                        wr_data_next = {data_reg[14:0], mdio_s2_reg};
                        state_next = lpa_pkg::LPA_PRE;
                    end
                end
                default: begin
                    state_next = lpa_pkg::LPA_PRE;
                    pre_cnt_next = 6'h00;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= lpa_pkg::LPA_PRE;
            pre_cnt_reg <= 6'h00;
            bit_cnt_reg <= 5'h00;
            hdr_reg <= 12'h000;
            data_reg <= 16'h0000;
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_data_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            pre_cnt_reg <= pre_cnt_next;
            bit_cnt_reg <= bit_cnt_next;
            hdr_reg <= hdr_next;
            data_reg <= data_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            wr_en_reg <= wr_en_next;
            wr_data_reg <= wr_data_next;
        end
    end

    assign mdio_out = out_reg;
    assign mdio_oe = oe_reg;

    // =========================================================================
    // Partner ability register
    // =========================================================================
    lpa_ability_reg u_ability (
        .mclk(mclk),
        .rst(rst),
        .load(code_word_valid),
        .code_word(code_word),
        .wr_en(wr_en_reg),
        .wr_data(wr_data_reg),
        .command_override_write(command_override_write),
        .value(reg_value)
    );

    assign partner_ability = reg_value;

endmodule // lpa_mgmt

/* dv/lpa_mgmt_chk.sv */
// ====================
// Checker on the register block ports.
// ====================
module lpa_mgmt_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic [4:0] phy_addr,
    input wire logic command_override_write,
    input wire logic code_word_valid,
    input wire logic [15:0] code_word,
    input wire logic [15:0] partner_ability
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    reset_clear_a:
    assert property (disable iff (1'b0) rst |=> !mdio_oe && partner_ability == 16'h0000)
        else $error("register or pin drive not clear after reset");
    load_flags_a:
    assert property (code_word_valid |=> partner_ability[15:13] == $past(code_word[15:13]))
        else $error("flags not loaded from code word");
    load_tech_a:
    assert property (code_word_valid |=> partner_ability[8:5] == $past(code_word[8:5]))
        else $error("ability bits not loaded from code word");
    load_sel_a:
    assert property (code_word_valid |=> partner_ability[4:0] == $past(code_word[4:0]))
        else $error("selector not loaded from code word");
    fixed_zero_a:
    assert property (partner_ability[12:9] == 4'h0)
        else $error("unsupported or reserved bit set");
    ro_hold_a:
    assert property (!code_word_valid |=> $stable(partner_ability[15:4]))
        else $error("read-only bits changed without a load");
    ovr_guard_a:
    assert property (!command_override_write && !code_word_valid
        |=> partner_ability[3:0] == $past(partner_ability[3:0]))
        else $error("selector changed while override low");
    ta_drive_a:
    assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*8])
        else $error("turnaround drive wrong");
    pin_timing_a:
    assert property ($changed(mdio_oe) |-> $past(mdc, 3) && !$past(mdc, 4))
        else $error("pin drive changed away from a clock rise");
    cover property (code_word_valid);
    cover property ($rose(mdio_oe));
    cover property (command_override_write && $changed(partner_ability[3:0]));
endmodule // lpa_mgmt_chk

bind lpa_mgmt lpa_mgmt_chk u_chk (.mclk, .rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_addr,
    .command_override_write, .code_word_valid, .code_word, .partner_ability);

/* dv/lpa_sta_model.sv */
// ====================
// Station manager model that runs management frames.
// ====================
module lpa_mgr_model (
    input wire logic mclk,
    output logic mdc,
    output logic mgr_out,
    output logic mgr_en,
    input wire logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mdc = 1'b0;
        mgr_out = 1'b0;
        mgr_en = 1'b0;
    end
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            @(posedge mclk);
            mdc <= 1'b0;
            mgr_en <= !(op == lpa_pkg::LPA_OP_READ && i >= 46);
            mgr_out <= f[63 - i];
            repeat (5) @(posedge mclk);
            if (i >= 48) rd = {rd[14:0], line};
            mdc <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        @(posedge mclk);
        mdc <= 1'b0;
        mgr_en <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule // lpa_mgr_model

/* dv/tb_top.sv */
// ====================
// Testbench for the partner ability register.
// ====================
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cow = 1'b0;
    logic cword_vld = 1'b0;
    logic [15:0] cword = 16'h0000;
    logic mdc, mgr_out, mgr_en, mdio_out, mdio_oe;
    logic [15:0] pa, rd;
    logic [15:0] words [4] = '{16'hffff, 16'h4021, 16'ha1e2, 16'h0000};
    wire mdio_line = mdio_oe ? mdio_out : (mgr_en ? mgr_out : 1'b1);
    int n_fail = 0;
    int compares = 0;
    always #12.5 mclk = ~mclk;
    lpa_mgr_model u_mgr (.mclk(mclk), .mdc(mdc), .mgr_out(mgr_out), .mgr_en(mgr_en),
        .line(mdio_line));
    lpa_mgmt u_dut (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(5'h0b),
        .command_override_write(cow), .code_word_valid(cword_vld), .code_word(cword),
        .partner_ability(pa));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        u_mgr.xfer(lpa_pkg::LPA_OP_READ, a, lpa_pkg::LPA_REG_ADDR, 16'h0000, rd);
        chk(rd, exp);
    endtask
    task automatic load(input logic [15:0] w);
        @(posedge mclk);
        cword_vld <= 1'b1;
        cword <= w;
        @(posedge mclk);
        cword_vld <= 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic t_reset();
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk(pa, 16'h0000);
        rd_chk(5'h0b, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_load();
        // Selectors 00001b and 00010b both appear among the words.
        foreach (words[i]) begin
            load(words[i]);
            chk(pa, words[i] & 16'he1ff);
            rd_chk(5'h0b, words[i] & 16'he1ff);
        end
        $display("test load done");
    endtask
    task automatic t_write();
        load(16'h2041);
        u_mgr.xfer(lpa_pkg::LPA_OP_WRITE, 5'h0b, 5'h05, 16'h000a, rd);
        chk(pa, 16'h2041);
        @(posedge mclk);
        cow <= 1'b1;
        u_mgr.xfer(lpa_pkg::LPA_OP_WRITE, 5'h0c, 5'h05, 16'h000a, rd);
        u_mgr.xfer(lpa_pkg::LPA_OP_WRITE, 5'h0b, 5'h04, 16'h000a, rd);
        chk(pa, 16'h2041);
        // Reserved bits are written with their default of zero.
        u_mgr.xfer(lpa_pkg::LPA_OP_WRITE, 5'h0b, 5'h05, 16'h800a, rd);
        chk(pa, 16'h204a);
        @(posedge mclk);
        cow <= 1'b0;
        rd_chk(5'h0c, 16'hffff);
        rd_chk(5'h0b, 16'h204a);
        $display("test write done");
    endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_load();
        t_write();
        t_reset();
        stop_test();
    end
endmodule // tb_top
